// [src/flash_pin_params.svh]
`ifndef FLASH_PIN_PARAMS_SVH
`define FLASH_PIN_PARAMS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define FP_CLK_PERIOD_PS 5000
`define FP_INIT_NS       1000
`define FP_INIT_CYCLES \
    ((`FP_INIT_NS * 1000 + `FP_CLK_PERIOD_PS - 1) / `FP_CLK_PERIOD_PS)

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define FP_ADDR_W        8
`define FP_OFS_CTRL      8'h00
`define FP_OFS_STATUS    8'h04
`define FP_OFS_HOST_DATA 8'h08
`define FP_OFS_HOST_ADDR 8'h0c
`define FP_OFS_READBACK  8'h10

// ----------------------------------------
// control fields
// ----------------------------------------
`define FP_CTRL_DMA      0
`define FP_CTRL_IRQ      1
`define FP_CTRL_PROT_LO  2
`define FP_CTRL_PROT_HI  3

// ----------------------------------------
// status fields
// ----------------------------------------
`define FP_ST_BUSY       0
`define FP_ST_WIDE       1
`define FP_ST_POS_LO     2
`define FP_ST_POS_HI     3
`define FP_ST_LOCK       4
`define FP_ST_SLEEP      5
`define FP_ST_PROT_HIT   6

// ----------------------------------------
// host address decode
// ----------------------------------------
`define FP_POS_HI        12
`define FP_POS_LO        11
`define FP_PART_BIT      10

`endif

// [src/flash_pin_pkg.sv]
package flash_pin_pkg;

    // gray codes along init -> ready -> sleep
    typedef enum logic [1:0]
    {
        ST_INIT  = 2'b00,
        ST_READY = 2'b01,
        ST_SLEEP = 2'b11
    } link_state_type;

endpackage

// [src/flash_disk_host_pin_config.sv]
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "flash_pin_params.svh"

module flash_disk_host_pin_config
    import flash_pin_pkg::*;
#(
    parameter int INIT_CYCLES = `FP_INIT_CYCLES
)
(
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic [12:1]           host_addr,
    input  wire logic [15:0]           host_data_in,
    output logic      [15:0]           host_data_out,
    output logic                       host_data_lo_oe,
    output logic                       host_data_hi_oe,
    input  wire logic                  chip_enable_n,
    input  wire logic                  read_strobe_n,
    input  wire logic                  write_strobe_n,
    input  wire logic                  deep_sleep_in,
    input  wire logic                  strap_width,
    input  wire logic [1:0]            cascade_position_strap,
    input  wire logic                  lock_n,
    output logic                       busy_n_out,
    output logic                       busy_n_oe,
    output logic                       dma_request_n_out,
    output logic                       dma_request_n_oe,
    output logic                       irq_n_out,
    output logic                       irq_n_oe,
    input  wire logic [`FP_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic      [31:0]           reg_rdata
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    localparam int PIN_W = 36;
    // idle levels, so no false strobe edge or lock follows reset
    localparam logic [PIN_W-1:0] PIN_IDLE = {5'b11101, 31'h0};

    logic [PIN_W-1:0] pin_meta;
    logic [PIN_W-1:0] pin_sync;
    wire  [PIN_W-1:0] pin_raw;

    assign pin_raw = {chip_enable_n, read_strobe_n, write_strobe_n,
                      deep_sleep_in, lock_n, strap_width,
                      cascade_position_strap, host_addr, host_data_in};

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta <= PIN_IDLE;
            pin_sync <= PIN_IDLE;
        end
        else
        begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    wire        s_ce_n;
    wire        s_oe_n;
    wire        s_we_n;
    wire        s_sleep;
    wire        s_lock_n;
    wire        s_width;
    wire [1:0]  s_pos;
    wire [12:1] s_addr;
    wire [15:0] s_data;

    assign {s_ce_n, s_oe_n, s_we_n, s_sleep, s_lock_n, s_width,
            s_pos, s_addr, s_data} = pin_sync;

    // ----------------------------------------
    // state and init timer
    // ----------------------------------------
    link_state_type state;
    link_state_type next_state;
    logic [15:0]    init_cnt;
    logic           wide16;
    logic [1:0]     position;

    wire init_done = init_cnt == 16'(INIT_CYCLES - 1);

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_INIT:  if (init_done) next_state = ST_READY;
            // in narrow mode the pin is an address line, never a sleep
            ST_READY: if (wide16 && s_sleep) next_state = ST_SLEEP;
            ST_SLEEP: if (!s_sleep) next_state = ST_READY;
            default:  next_state = ST_INIT;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state    <= ST_INIT;
            init_cnt <= '0;
        end
        else
        begin
            state    <= next_state;
            init_cnt <= (state == ST_INIT) ? init_cnt + 16'h0001 : '0;
        end
    end

    // straps are followed during init and frozen once ready
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wide16   <= 1'b0;
            position <= 2'h0;
        end
        else if (state == ST_INIT)
        begin
            wide16   <= s_width;
            position <= s_pos;
        end
    end

    // ----------------------------------------
    // host cycle decode
    // ----------------------------------------
    logic [1:0]  protect_mask;
    logic [15:0] readback;
    logic        we_prev;

    wire in_window = s_addr[`FP_POS_HI:`FP_POS_LO] == position;
    wire selected  = !s_ce_n && state == ST_READY && in_window;
    wire lock_on   = !s_lock_n;
    wire protected_hit = lock_on && protect_mask[s_addr[`FP_PART_BIT]];
    wire rd_active = selected && !s_oe_n;
    wire wr_end    = selected && s_we_n && !we_prev;
    wire host_write_event = wr_end && !protected_hit;
    wire prot_event = protected_hit && (wr_end || rd_active);
    wire byte_a0   = s_sleep;
    wire [15:0] in_word = wide16 ? s_data : {8'h00, s_data[7:0]};
    wire [15:0] narrow_out = byte_a0 ? {8'h00, readback[15:8]}
                                     : {8'h00, readback[7:0]};
    wire [15:0] next_data_out = protected_hit ? 16'h0000
                              : (wide16 ? readback : narrow_out);
    wire [12:0] host_word_addr = wide16 ? {s_addr, 1'b0}
                                        : {s_addr, byte_a0};

    // ----------------------------------------
    // host data path
    // ----------------------------------------
    logic [15:0] host_wdata;
    logic [12:0] host_waddr;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            we_prev         <= 1'b1;
            host_data_out   <= '0;
            host_data_lo_oe <= 1'b0;
            host_data_hi_oe <= 1'b0;
        end
        else
        begin
            we_prev         <= s_we_n;
            host_data_out   <= next_data_out;
            host_data_lo_oe <= rd_active;
            host_data_hi_oe <= rd_active && wide16;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_wdata <= '0;
            host_waddr <= '0;
        end
        else if (host_write_event)
        begin
            host_wdata <= in_word;
            host_waddr <= host_word_addr;
        end
    end

    // ----------------------------------------
    // open-drain status lines
    // ----------------------------------------
    logic [31:0] ctrl;

    // pins are only ever pulled low; the enable alone carries the state
    assign busy_n_out        = 1'b0;
    assign dma_request_n_out = 1'b0;
    assign irq_n_out         = 1'b0;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_n_oe        <= 1'b0;
            dma_request_n_oe <= 1'b0;
            irq_n_oe         <= 1'b0;
        end
        else
        begin
            busy_n_oe        <= next_state == ST_INIT;
            dma_request_n_oe <= ctrl[`FP_CTRL_DMA];
            irq_n_oe         <= ctrl[`FP_CTRL_IRQ];
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    logic prot_hit_flag;

    wire wr_ctrl   = reg_write && reg_addr == `FP_OFS_CTRL;
    wire wr_status = reg_write && reg_addr == `FP_OFS_STATUS;
    wire wr_rback  = reg_write && reg_addr == `FP_OFS_READBACK;
    wire clr_prot  = wr_status && reg_wdata[`FP_ST_PROT_HIT];

    assign protect_mask = ctrl[`FP_CTRL_PROT_HI:`FP_CTRL_PROT_LO];

    wire [31:0] status_word = {25'h0, prot_hit_flag,
                               state == ST_SLEEP, lock_on, position,
                               wide16, state == ST_INIT};

    wire [31:0] read_mux =
        reg_addr == `FP_OFS_CTRL      ? ctrl :
        reg_addr == `FP_OFS_STATUS    ? status_word :
        reg_addr == `FP_OFS_HOST_DATA ? {16'h0, host_wdata} :
        reg_addr == `FP_OFS_HOST_ADDR ? {19'h0, host_waddr} :
        reg_addr == `FP_OFS_READBACK  ? {16'h0, readback} : 32'h0;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl          <= '0;
            readback      <= '0;
            prot_hit_flag <= 1'b0;
            reg_rdata     <= '0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= {28'h0, reg_wdata[3:0]};
            if (wr_rback)
                readback <= reg_wdata[15:0];
            // a new hit in the clearing cycle is kept
            prot_hit_flag <= prot_event || (prot_hit_flag && !clr_prot);
            reg_rdata     <= reg_read ? read_mux : 32'h0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence busy_hold_seq;
        busy_n_oe [*8];
    endsequence

    sequence read_seen_seq;
        rd_active ##1 host_data_lo_oe;
    endsequence

    busy_release_a: assert property (
        $fell(busy_n_oe) |-> state == ST_READY)
        else $error("busy released outside ready");

    init_hold_a: assert property (
        $rose(busy_n_oe) |-> busy_hold_seq)
        else $error("busy dropped too early");

    width_freeze_a: assert property (
        state != ST_INIT && $past(state) != ST_INIT |-> $stable(wide16))
        else $error("width changed after init");

    upper_quiet_a: assert property (
        !wide16 |=> !host_data_hi_oe || $past(wide16))
        else $error("upper byte driven in narrow mode");

    read_drive_a: assert property (
        host_data_lo_oe |-> $past(rd_active))
        else $error("bus driven without read cycle");

    read_follow_a: assert property (
        rd_active |-> read_seen_seq)
        else $error("read cycle not driven");

    sleep_enter_a: assert property (
        state == ST_READY && wide16 && s_sleep |=> state == ST_SLEEP)
        else $error("deep sleep not entered");

    narrow_awake_a: assert property (
        !wide16 && state == ST_READY |=> state != ST_SLEEP)
        else $error("narrow mode slept on address bit");

    lock_block_a: assert property (
        wr_end && protected_hit |=> $stable(host_wdata))
        else $error("protected write accepted");

    window_pick_a: assert property (
        host_data_lo_oe |-> $past(s_addr[`FP_POS_HI:`FP_POS_LO]) == position)
        else $error("answered outside own window");

    dma_pull_a: assert property (
        dma_request_n_oe == $past(ctrl[`FP_CTRL_DMA]))
        else $error("dma request line wrong");

    irq_pull_a: assert property (
        irq_n_oe == $past(ctrl[`FP_CTRL_IRQ]))
        else $error("interrupt line wrong");

endmodule

// [verif/host_bus_model.sv]
`timescale 1ns/1ps
module host_bus_model
(
    input  wire logic        core_clk,
    input  wire logic        busy_n_oe,
    input  wire logic [15:0] host_data_out,
    input  wire logic        host_data_lo_oe,
    input  wire logic        host_data_hi_oe,
    output logic      [12:1] host_addr,
    output logic      [15:0] host_data_in,
    output logic             chip_enable_n,
    output logic             read_strobe_n,
    output logic             write_strobe_n
);
    logic [15:0] drive;
    logic        drive_en;
    logic [15:0] pins;

    // a released bus shows the inverse of the last value, not a stale copy
    assign pins = drive_en ? drive : ~drive;
    assign host_data_in[7:0] = host_data_lo_oe ? host_data_out[7:0]
                                               : pins[7:0];
    assign host_data_in[15:8] = host_data_hi_oe ? host_data_out[15:8]
                                                : pins[15:8];

    initial
    begin
        host_addr = 12'h000;
        drive = 16'h0000;
        drive_en = 1'b0;
        chip_enable_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
    end

    // strobes held five edges, well over the two-cycle sync delay
    task automatic access(input logic ce, input logic rd,
                          input logic [12:1] a, input logic [15:0] d,
                          output logic [15:0] q, output logic [1:0] oe);
        while (busy_n_oe)
            @(posedge core_clk);
        @(posedge core_clk);
        host_addr <= a;
        drive <= d;
        drive_en <= !rd;
        chip_enable_n <= !ce;
        read_strobe_n <= !rd;
        write_strobe_n <= rd;
        repeat (4) @(posedge core_clk);
        #1 q = host_data_in;
        oe = {host_data_hi_oe, host_data_lo_oe};
        @(posedge core_clk);
        read_strobe_n <= 1'b1;
        write_strobe_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        chip_enable_n <= 1'b1;
        drive_en <= 1'b0;
        repeat (5) @(posedge core_clk);
    endtask
endmodule

// [verif/flash_disk_host_pin_config_test.sv]
`timescale 1ns/1ps
`include "flash_pin_params.svh"
module flash_disk_host_pin_config_test;
    localparam int INIT = 10;
    logic        core_clk, rst_n, deep_sleep_in, strap_width, lock_n;
    logic [1:0]  cascade_position_strap;
    logic [12:1] host_addr;
    logic [15:0] host_data_in, host_data_out, rnd, rb, q;
    logic        chip_enable_n, read_strobe_n, write_strobe_n;
    logic        host_data_lo_oe, host_data_hi_oe, busy_n_oe, busy_n_out;
    logic        dma_request_n_out, dma_request_n_oe, irq_n_out, irq_n_oe;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic        reg_write, reg_read;
    logic [1:0]  oe;
    int          num_errors, check_count;
    // rule model: straps, readback, protection and accepted host writes
    int          m_wide, m_pos, m_mask, m_lock;
    logic [15:0] m_rb;
    logic [17:0] e;
    logic [31:0] w;
    logic [31:0] wq[$];

    flash_disk_host_pin_config #(.INIT_CYCLES(INIT))
        u_flash_disk_host_pin_config
    (
        .core_clk, .rst_n, .host_addr, .host_data_in, .host_data_out,
        .host_data_lo_oe, .host_data_hi_oe, .chip_enable_n, .read_strobe_n,
        .write_strobe_n, .deep_sleep_in, .strap_width,
        .cascade_position_strap, .lock_n, .busy_n_out, .busy_n_oe,
        .dma_request_n_out, .dma_request_n_oe, .irq_n_out, .irq_n_oe,
        .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata
    );

    host_bus_model u_host_bus_model
    (
        .core_clk, .busy_n_oe, .host_data_out, .host_data_lo_oe,
        .host_data_hi_oe, .host_addr, .host_data_in, .chip_enable_n,
        .read_strobe_n, .write_strobe_n
    );

    always #2.5 core_clk = ~core_clk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // straps only count while busy, so each setting needs a fresh reset
    task automatic do_reset(input logic w, input logic [1:0] pos);
        int n;
        n = 0;
        m_wide = w;
        m_pos = pos;
        m_mask = 0;
        m_rb = 16'h0000;
        @(posedge core_clk);
        rst_n <= 1'b0;
        strap_width <= w;
        cascade_position_strap <= pos;
        repeat (12) @(posedge core_clk);
        #1 check({busy_n_oe, dma_request_n_oe, irq_n_oe}, 32'h0);
        @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3 * INIT)
        begin
            @(posedge core_clk);
            #1 n += busy_n_oe;
        end
        check(n, INIT - 1);
    endtask

    task automatic host_rd(input logic [12:1] a);
        u_host_bus_model.access(1'b1, 1'b1, a, 16'h0000, q, oe);
    endtask

    // expected {hi_oe, lo_oe, data} of a host read, from the rules
    function automatic logic [17:0] model_rd(input logic [12:1] a,
                                             input logic a0);
        logic [15:0] v;
        v = m_wide ? m_rb : {8'h00, a0 ? m_rb[15:8] : m_rb[7:0]};
        if (a[12:11] != m_pos[1:0])
            return 18'h0;
        if (m_lock && m_mask[a[10]])
            v = 16'h0000;
        return {1'(m_wide), 1'b1, v};
    endfunction

    // a write the rules let through is queued as {addr, a0, data}
    task automatic host_wr(input logic [12:1] a, input logic [15:0] v);
        u_host_bus_model.access(1'b1, 1'b0, a, v, q, oe);
        if (a[12:11] == m_pos[1:0] && !(m_lock && m_mask[a[10]]))
            wq.push_back({3'b000, a, m_wide ? 1'b0 : deep_sleep_in,
                          m_wide ? v : {8'h00, v[7:0]}});
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        deep_sleep_in = 1'b0;
        strap_width = 1'b1;
        cascade_position_strap = 2'b00;
        lock_n = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        rnd = 16'h004f;
        do_reset(1'b1, 2'b10);
        reg_rd(`FP_OFS_STATUS, d);
        check(d, 32'h0000000a);
        for (int k = 0; k < 4; k++)
        begin
            reg_wr(`FP_OFS_CTRL, k);
            repeat (2) @(posedge core_clk);
            #1 check({irq_n_oe, dma_request_n_oe, irq_n_out,
                      dma_request_n_out}, k << 2);
        end
        reg_wr(`FP_OFS_CTRL, 32'h0);
        rb = lfsr(rnd);
        reg_wr(`FP_OFS_READBACK, rb);
        m_rb = rb;
        for (int j = 0; j < 4; j++)
        begin
            host_rd({j[1:0], 10'h005});
            e = model_rd({j[1:0], 10'h005}, 1'b0);
            check(oe, e[17:16]);
            if (e[17:16] != 2'b00)
                check(q, e[15:0]);
        end
        u_host_bus_model.access(1'b0, 1'b1, 12'h805, 16'h0000, q, oe);
        check(oe, 2'b00);
        rnd = lfsr(rb);
        host_wr(12'h812, rnd);
        w = wq[$];
        reg_rd(`FP_OFS_HOST_DATA, d);
        check(d, {16'h0, w[15:0]});
        reg_rd(`FP_OFS_HOST_ADDR, d);
        check(d, {19'h0, w[28:16]});
        reg_wr(`FP_OFS_CTRL, 32'h8);
        m_mask = 2;
        lock_n <= 1'b0;
        m_lock = 1;
        host_wr(12'ha12, lfsr(rnd));
        w = wq[$];
        reg_rd(`FP_OFS_HOST_DATA, d);
        check(d, {16'h0, w[15:0]});
        host_rd(12'ha05);
        check({oe, q}, model_rd(12'ha05, 1'b0));
        reg_rd(`FP_OFS_STATUS, d);
        check(d, 32'h0000005a);
        lock_n <= 1'b1;
        m_lock = 0;
        @(posedge core_clk);
        deep_sleep_in <= 1'b1;
        repeat (4) @(posedge core_clk);
        reg_rd(`FP_OFS_STATUS, d);
        check(d & 32'h20, 32'h20);
        host_rd(12'h805);
        check(oe, 2'b00);
        deep_sleep_in <= 1'b0;
        host_rd(12'h805);
        check({oe, q}, model_rd(12'h805, 1'b0));
        // both request lines pulled, so the reset check below can bite
        reg_wr(`FP_OFS_CTRL, 32'h3);
        do_reset(1'b0, 2'b01);
        reg_rd(`FP_OFS_STATUS, d);
        check(d, 32'h00000004);
        rb = lfsr(rnd);
        reg_wr(`FP_OFS_READBACK, rb);
        m_rb = rb;
        for (int s = 0; s < 2; s++)
        begin
            @(posedge core_clk);
            deep_sleep_in <= s[0];
            host_rd(12'h405);
            e = model_rd(12'h405, s[0]);
            check({oe, q[7:0]}, {e[17:16], e[7:0]});
        end
        rnd = lfsr(rb);
        host_wr(12'h412, rnd);
        w = wq[$];
        reg_rd(`FP_OFS_HOST_ADDR, d);
        check(d, {19'h0, w[28:16]});
        reg_rd(`FP_OFS_HOST_DATA, d);
        check(d, {16'h0, w[15:0]});
        report_and_stop();
    end

    initial
    begin
        #100000;
        num_errors++;
        report_and_stop();
    end
endmodule
